// *** tb.sv ***
// Self-checking bench of the USB global event interrupt block.
`timescale 1ns/10ps
module tb;
   localparam logic [11:0] AF = usbgi_pkg::ADDR_FLAGS;
   localparam logic [11:0] AE = usbgi_pkg::ADDR_IRQ_EN;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ep_irq = 0;
   logic pready, pslverr, usb_irq, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic [7:0] fl = '0, en = 8'h10, rnd = 8'h23;
   usbgi_pkg::usbgi_evt_t bus_evt;
   int fail_count = 0, samples_checked = 0;
   always #50 pclk = ~pclk;
   usbgi_host_model u_host (.*);
   usbgi_top #(.SUSP_CYCLES(20)) u_dut (.*);
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %0t %h %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(r, {24'h0, e});
   endtask
   task automatic irq;
      #1 chk({31'h0, usb_irq}, {31'h0, |(fl & en) | ep_irq});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge pclk);
      fail_count++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(AE, 8'h10);
      rd(AF, 8'h00);
      apb(1'b1, 12'h100, 8'hff);
      chk({31'h0, err}, 32'h1);
      repeat (4) begin
         rnd = lfsr(rnd);
         apb(1'b1, AE, rnd & 8'h39);
         en = rnd & 8'h39;
         rd(AE, en);
      end
      apb(1'b1, AE, 8'h39);
      en = 8'h39;
      u_host.pulse(0);
      fl = 8'h08;
      rd(AF, fl);
      irq;
      u_host.pulse(1);
      fl = 8'h18;
      repeat (30) @(posedge pclk);
      rd(AF, fl);
      // The clearing write and a new frame land on the same edge; the set must win.
      fork
         apb(1'b1, AF, 8'h00);
         begin
            @(posedge pclk);
            u_host.pulse(0);
         end
      join
      fl = 8'h08;
      rd(AF, fl);
      apb(1'b1, AE, 8'h00);
      en = 8'h00;
      irq;
      apb(1'b1, AE, 8'h39);
      en = 8'h39;
      apb(1'b1, AF, 8'h00);
      u_host.idle(25, 1'b1);
      fl = 8'h01;
      rd(AF, fl);
      u_host.idle(25, 1'b0);
      fl = 8'h21;
      rd(AF, fl);
      apb(1'b1, AE, 8'h20);
      en = 8'h20;
      // Clocks are taken as running again before the wake flag is cleared.
      apb(1'b1, AF, 8'h19);
      fl = 8'h01;
      irq;
      apb(1'b1, AE, 8'h01);
      en = 8'h01;
      irq;
      apb(1'b1, AE, 8'h00);
      en = 8'h00;
      irq;
      @(posedge pclk) presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      en = 8'h10;
      fl = 8'h00;
      rd(AE, en);
      rd(AF, fl);
      irq;
      @(posedge pclk) ep_irq <= 1'b1;
      @(posedge pclk);
      irq;
      rd(usbgi_pkg::ADDR_STATE, 8'h02);
      give_verdict;
   end
endmodule

// *** usbgi_host_model.sv ***
// Behavioural USB host driving line events into the block.
`timescale 1ns/10ps
module usbgi_host_model (
   input wire logic              pclk,
   output usbgi_pkg::usbgi_evt_t bus_evt
);
   initial bus_evt = '0;
   task automatic pulse(input int b);
      @(posedge pclk) bus_evt[b] <= 1'b1;
      @(posedge pclk) bus_evt[b] <= 1'b0;
   endtask
   // Hold the idle state, then leave it, by own resume if asked.
   task automatic idle(input int n, input logic own);
      @(posedge pclk) bus_evt.line_idle <= 1'b1;
      repeat (n) @(posedge pclk);
      bus_evt.line_idle <= 1'b0;
      bus_evt.upstream_resume <= own;
      @(posedge pclk) bus_evt.upstream_resume <= 1'b0;
   endtask
endmodule

// *** usbgi_monitor.sv ***
// Checker of register answers and interrupt relations of the USB event block.
`timescale 1ns/10ps
module usbgi_monitor #(parameter int SUSP_CYCLES = 20) (
   input wire logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, ep_irq, usb_irq,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata, prdata,
   input wire usbgi_pkg::usbgi_evt_t bus_evt
);
   logic [7:0] en_q, en_d;
   // Shadow of the enable register, so the reset end and frame start flags are weighed by their own masks.
   assign en_d = (psel && penable && pwrite && paddr == usbgi_pkg::ADDR_IRQ_EN) ? pwdata[7:0] & 8'h39 : en_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) en_q <= 8'h10;
      else en_q <= en_d;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_rst; bus_evt.bus_reset_end && en_d[4] |=> usb_irq; endproperty
   a_rst: assert property (p_rst) else $error("reset end irq");
   property p_sof; bus_evt.frame_start_pid && en_d[3] |=> usb_irq; endproperty
   a_sof: assert property (p_sof) else $error("frame irq");
   property p_mask; en_d == 8'h00 && !ep_irq |=> !usb_irq; endproperty
   a_mask: assert property (p_mask) else $error("masked irq");
   property p_ep; ep_irq |=> usb_irq; endproperty
   a_ep: assert property (p_ep) else $error("ep irq");
   property p_resv; pready && !pwrite && paddr != usbgi_pkg::ADDR_STATE |-> (prdata & ~32'h39) == 32'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits");
   property p_en; pready && !pwrite && paddr == usbgi_pkg::ADDR_IRQ_EN |-> prdata[7:0] == en_q; endproperty
   a_en: assert property (p_en) else $error("enable read");
   property p_hold; usb_irq && !$past(ep_irq) && !(psel && pwrite) |=> usb_irq; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   cover property (pslverr);
   cover property (bus_evt.frame_start_pid && en_d[3]);
   cover property (ep_irq ##1 usb_irq);
endmodule
bind usbgi_top usbgi_monitor #(.SUSP_CYCLES(SUSP_CYCLES)) u_mon (.*);

// *** usbgi_pkg.sv ***
// Constants, register map and event carrier of the USB global event interrupt block.
// Function
// - Set wake flag, bit 5, when suspended and bus lines leave idle.
// - Own upstream resume signalling never sets the wake flag.
// - Wake flag drives the interrupt only while its enable is set.
// - Set reset end flag, bit 4, when a bus reset has finished.
// - Reset end flag drives the interrupt only while its enable is set.
// - Set frame start flag, bit 3, on every start of frame token.
// - Frame start flag drives the interrupt only while its enable is set.
// - Reset end and frame start flags stay set until software clears them.
// - Suspend flag, bit 0, drives the interrupt only while its enable is set.
// - Enable register resets to 10h, only reset end interrupt enabled.
// - Reserved bits 7-6, 2, 1 read zero; software writes them zero.
// - Set suspend flag after a prolonged idle state on the bus.
package usbgi_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   // Printed offsets are indices; the byte address is four times each.
   localparam logic [7:0]  IDX_FLAGS    = 8'hbd;
   localparam logic [7:0]  IDX_IRQ_EN   = 8'hbe;
   localparam logic [7:0]  IDX_STATE    = 8'hbf;
   localparam logic [11:0] ADDR_FLAGS   = {2'h0, IDX_FLAGS, 2'h0};
   localparam logic [11:0] ADDR_IRQ_EN  = {2'h0, IDX_IRQ_EN, 2'h0};
   localparam logic [11:0] ADDR_STATE   = {2'h0, IDX_STATE, 2'h0};

   // ***************************************************************
   // Field layout and reset values
   // ***************************************************************
   localparam int          BIT_WAKE     = 5;
   localparam int          BIT_RST_END  = 4;
   localparam int          BIT_FRAME    = 3;
   localparam int          BIT_SUSPEND  = 0;
   localparam int          BIT_ST_SUSP  = 0;
   localparam int          BIT_ST_IRQ   = 1;
   localparam logic [7:0]  IMPL_MASK    = 8'h39;
   localparam logic [7:0]  RST_IRQ_EN   = 8'h10;
   localparam logic [7:0]  RST_FLAGS    = 8'h00;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int          CLK_KHZ      = 10000;
   localparam int          SUSP_TIME_US = 3000;
   localparam int          SUSP_CYCLES  = (SUSP_TIME_US * CLK_KHZ) / 1000;
   localparam int          SUSP_CNT_W   = 16;

   // ***************************************************************
   // Bus event carrier
   // ***************************************************************
   typedef struct packed {
      logic line_idle;
      logic upstream_resume;
      logic bus_reset_end;
      logic frame_start_pid;
   } usbgi_evt_t;

endpackage

// *** usbgi_top.sv ***
// APB register slave and event flag logic of the USB global event interrupt block.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module usbgi_top #(
   parameter int SUSP_CYCLES = usbgi_pkg::SUSP_CYCLES
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // USB line events
   input  wire usbgi_pkg::usbgi_evt_t bus_evt,
   input  wire logic                  ep_irq,
   // Interrupt
   output logic                       usb_irq
);

   // ***************************************************************
   // Register decode
   // ***************************************************************
   logic [7:0]                 flags_q;
   logic [7:0]                 flags_d;
   logic [7:0]                 irq_en_q;
   logic [7:0]                 set_v;
   logic                       suspended_q;
   logic [usbgi_pkg::SUSP_CNT_W-1:0] idle_cnt_q;
   logic                       susp_hit;
   logic                       wake_hit;
   logic                       acc;
   logic                       wr_flags;
   logic                       wr_en;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   // One access cycle: pready rises in the cycle after setup.
   assign acc      = psel & penable & pready;
   assign wr_flags = acc & pwrite & hit(paddr, usbgi_pkg::ADDR_FLAGS);
   assign wr_en    = acc & pwrite & hit(paddr, usbgi_pkg::ADDR_IRQ_EN);

   // ***************************************************************
   // Suspend detection
   // ***************************************************************
   // Counting stops once suspended, so one idle stretch raises one flag.
   assign susp_hit = bus_evt.line_idle & ~suspended_q &
                     (idle_cnt_q == usbgi_pkg::SUSP_CNT_W'(SUSP_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_q <= '0;
      end else if (!bus_evt.line_idle || suspended_q) begin
         idle_cnt_q <= '0;
      end else begin
         idle_cnt_q <= idle_cnt_q + 1'b1;
      end
   end

   // Own resume signalling leaves suspend but does not count as a wake.
   assign wake_hit = suspended_q & ~bus_evt.line_idle & ~bus_evt.upstream_resume;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         suspended_q <= 1'b0;
      end else if (susp_hit) begin
         suspended_q <= 1'b1;
      end else if (!bus_evt.line_idle || bus_evt.bus_reset_end) begin
         suspended_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Event flags
   // ***************************************************************
   always_comb begin
      set_v                         = '0;
      set_v[usbgi_pkg::BIT_WAKE]    = wake_hit;
      set_v[usbgi_pkg::BIT_RST_END] = bus_evt.bus_reset_end;
      set_v[usbgi_pkg::BIT_FRAME]   = bus_evt.frame_start_pid;
      set_v[usbgi_pkg::BIT_SUSPEND] = susp_hit;
      flags_d = flags_q;
      if (wr_flags) begin
         flags_d = flags_q & pwdata[7:0];
      end
      // Hardware never clears; a set wins over a same-cycle clear.
      flags_d = (flags_d | set_v) & usbgi_pkg::IMPL_MASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= usbgi_pkg::RST_FLAGS;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q <= usbgi_pkg::RST_IRQ_EN;
      end else if (wr_en) begin
         irq_en_q <= pwdata[7:0] & usbgi_pkg::IMPL_MASK;
      end
   end

   // ***************************************************************
   // Interrupt output
   // ***************************************************************
   // Built from next-state values so the output follows with no extra lag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_irq <= 1'b0;
      end else begin
         usb_irq <= (|(flags_d & (wr_en ? pwdata[7:0] : irq_en_q)
                       & usbgi_pkg::IMPL_MASK)) | ep_irq;
      end
   end

   // ***************************************************************
   // APB answer
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            if (hit(paddr, usbgi_pkg::ADDR_FLAGS)) begin
               prdata[7:0] <= flags_q & usbgi_pkg::IMPL_MASK;
            end else if (hit(paddr, usbgi_pkg::ADDR_IRQ_EN)) begin
               prdata[7:0] <= irq_en_q;
            end else if (hit(paddr, usbgi_pkg::ADDR_STATE)) begin
               prdata[usbgi_pkg::BIT_ST_SUSP] <= suspended_q;
               prdata[usbgi_pkg::BIT_ST_IRQ]  <= usb_irq;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

endmodule
